// *** verilog/pss_slave.sv ***
// port shutdown pins plus two-wire slave with alert response
// assumes the serial clock drives the link domain and the host holds
// data a little past each falling serial clock edge
`timescale 1ns/1ps
module pss_slave #(
  parameter int EVT_W = 4
) (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic SERIAL_CLK_I,
  input wire logic SERIAL_DATA_IN_PIN_I,
  output logic SERIAL_DATA_OUT_PIN_O,
  output logic SERIAL_DATA_OUT_PIN_OE_O,
  input wire logic [3:0] ADDRESS_SELECT_PINS_I,
  input wire logic HARD_PORT_OFF_PIN_N_I,
  input wire logic PRIORITY_SHED_PIN_N_I,
  input wire logic AUTO_MODE_I,
  input wire logic [EVT_W-1:0] PORT_EVENT_I,
  output pss_pkg::pss_port_t PORT_CTRL_O,
  output logic INT_N_O,
  output logic INT_N_OE_O
);
  import pss_pkg::*;

  localparam int SHED_BOUND = SHED_MAX_CYC;

  // status byte has room for four event flags only
  generate
    if (EVT_W < 1 || EVT_W > ARG_W) begin : g_bad_evt_w
      $error("EVT_W must be 1 to 4");
    end
  endgenerate

  // ---------------------------------------------------------------
  // link domain: sampling on the rising serial clock
  // ---------------------------------------------------------------
  logic sda_pos_q;
  logic [7:0] shift_q;

  always_ff @(posedge SERIAL_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sda_pos_q <= 1'b1;
      shift_q <= 8'h00;
    end else begin
      sda_pos_q <= SERIAL_DATA_IN_PIN_I;
      shift_q <= {shift_q[6:0], SERIAL_DATA_IN_PIN_I};
    end
  end

  // ---------------------------------------------------------------
  // link domain: synchronisers for status, interrupt and address pins
  // ---------------------------------------------------------------
  // status bits are independent flags, so bitwise sync is enough
  localparam int LS_W = 8 + 1 + 4;
  logic [LS_W-1:0] ls_s1_q, ls_s2_q, ls_s3_q;
  logic [7:0] stat_byte_q;
  logic int_q;
  wire [LS_W-1:0] ls_src = {stat_byte_q, int_q, ADDRESS_SELECT_PINS_I};

  always_ff @(negedge SERIAL_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ls_s1_q <= '0;
      ls_s2_q <= '0;
      ls_s3_q <= '0;
    end else begin
      ls_s1_q <= ls_src;
      ls_s2_q <= ls_s1_q;
      ls_s3_q <= ls_s2_q;
    end
  end

  wire [7:0] stat_l = ls_s3_q[LS_W-1 -: 8];
  wire int_l = ls_s3_q[4];
  wire [3:0] ad_l = ls_s3_q[3:0];

  // ---------------------------------------------------------------
  // link domain: address decode and bus conditions
  // ---------------------------------------------------------------
  wire [6:0] addr_rx = shift_q[7:1];
  wire rw_rx = shift_q[0];
  wire [6:0] own_addr = {ADDR_PRIMARY_HI, ad_l};
  wire hit_primary = (addr_rx == own_addr);
  wire hit_bcast = (addr_rx == ADDR_BROADCAST) && !rw_rx;
  wire hit_ara = (addr_rx == ADDR_ALERT_RESP) && rw_rx && int_l;
  wire addr_hit = hit_primary || hit_bcast || hit_ara;
  // data moved while the clock was high: start or stop
  wire sda_now = SERIAL_DATA_IN_PIN_I;
  wire start_seen = sda_pos_q && !sda_now;
  wire stop_seen = !sda_pos_q && sda_now && !SERIAL_DATA_OUT_PIN_OE_O;
  wire [7:0] ara_byte = {own_addr, ALERT_ADDR_LSB};

  // ---------------------------------------------------------------
  // link domain: serial engine on the falling serial clock
  // ---------------------------------------------------------------
  pss_link_st_t st_q;
  logic [2:0] cnt_q;
  logic [7:0] tx_q;
  logic is_ara_q;
  logic rd_q;
  logic [7:0] cmd_q;
  logic cmd_tgl_q;
  logic ara_tgl_q;
  logic oe_q;

  // the slave only ever answers; nothing here starts a transfer
  // slave only
  always_ff @(negedge SERIAL_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      tx_q <= 8'h00;
      is_ara_q <= 1'b0;
      rd_q <= 1'b0;
      cmd_q <= 8'h00;
      cmd_tgl_q <= 1'b0;
      ara_tgl_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (start_seen && !oe_q) begin
      st_q <= ST_ADDR;
      cnt_q <= 3'h0;
      oe_q <= 1'b0;
    end else if (stop_seen) begin
      st_q <= ST_IDLE;
      oe_q <= 1'b0;
    end else begin
      case (st_q)
        ST_ADDR: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'(BIT_CNT_LAST)) begin
            st_q <= addr_hit ? ST_ACK_A : ST_IDLE;
            oe_q <= addr_hit;
            is_ara_q <= hit_ara && !hit_primary;
            // the ack bit shifts in next, so keep the direction now
            rd_q <= rw_rx;
          end
        end
        ST_ACK_A: begin
          cnt_q <= 3'h0;
          if (rd_q) begin
            st_q <= ST_TX;
            tx_q <= is_ara_q ? ara_byte : stat_l;
            oe_q <= is_ara_q ? !ara_byte[7] : !stat_l[7];
          end else begin
            st_q <= ST_RX;
            oe_q <= 1'b0;
          end
        end
        ST_RX: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'(BIT_CNT_LAST)) begin
            st_q <= ST_ACK_W;
            oe_q <= 1'b1;
            cmd_q <= shift_q;
            cmd_tgl_q <= !cmd_tgl_q;
          end
        end
        ST_ACK_W: begin
          st_q <= ST_RX;
          cnt_q <= 3'h0;
          oe_q <= 1'b0;
        end
        ST_TX: begin
          if (tx_q[7] && !sda_pos_q) begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
          end else if (cnt_q == 3'(BIT_CNT_LAST)) begin
            st_q <= ST_ACK_R;
            oe_q <= 1'b0;
            if (is_ara_q) begin
              ara_tgl_q <= !ara_tgl_q;
            end
          end else begin
            cnt_q <= cnt_q + 3'h1;
            tx_q <= {tx_q[6:0], 1'b0};
            oe_q <= !tx_q[6];
          end
        end
        ST_ACK_R: begin
          cnt_q <= 3'h0;
          if (!sda_pos_q && !is_ara_q) begin
            st_q <= ST_TX;
            tx_q <= stat_l;
            oe_q <= !stat_l[7];
          end else begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // split data pin: out pin only ever pulls low
  // split data pin
  assign SERIAL_DATA_OUT_PIN_O = 1'b0;
  assign SERIAL_DATA_OUT_PIN_OE_O = oe_q;

  // ---------------------------------------------------------------
  // system domain: pin and toggle synchronisers
  // ---------------------------------------------------------------
  // a change counts only once the second and third stages agree
  localparam int SY_W = PIN_NUM + 2;
  logic [SY_W-1:0] sy_s1_q, sy_s2_q, sy_s3_q, sy_lvl_q;
  // pins idle high, toggles idle low as in the link domain
  localparam logic [SY_W-1:0] SY_RST = {2'b00, {PIN_NUM{1'b1}}};
  wire [SY_W-1:0] sy_src = {ara_tgl_q, cmd_tgl_q, AUTO_MODE_I,
                            PRIORITY_SHED_PIN_N_I, HARD_PORT_OFF_PIN_N_I};

  genvar gi;
  generate
    for (gi = 0; gi < SY_W; gi++) begin : g_sync
      always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          sy_s1_q[gi] <= SY_RST[gi];
          sy_s2_q[gi] <= SY_RST[gi];
          sy_s3_q[gi] <= SY_RST[gi];
          sy_lvl_q[gi] <= SY_RST[gi];
        end else begin
          sy_s1_q[gi] <= sy_src[gi];
          sy_s2_q[gi] <= sy_s1_q[gi];
          sy_s3_q[gi] <= sy_s2_q[gi];
          if (sy_s2_q[gi] == sy_s3_q[gi]) begin
            sy_lvl_q[gi] <= sy_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // toggle edges count only once the strap has been taken
  logic cmd_seen_q, ara_seen_q, sy_arm_q;
  wire cmd_evt = sy_arm_q && (sy_lvl_q[PIN_NUM] != cmd_seen_q);
  wire ara_evt = sy_arm_q && (sy_lvl_q[PIN_NUM+1] != ara_seen_q);

  // ---------------------------------------------------------------
  // system domain: command decode and port control
  // ---------------------------------------------------------------
  wire hard_act = !sy_lvl_q[PIN_HARD];
  wire shed_act = !sy_lvl_q[PIN_SHED];
  // strap read from agreeing stages: the level flop lags the take by one edge
  wire auto_lvl = sy_s2_q[PIN_AUTO] && sy_s3_q[PIN_AUTO];
  wire [3:0] op = cmd_q[OP_MSB:OP_LSB];
  wire [3:0] arg = cmd_q[ARG_W-1:0];
  wire op_power = cmd_evt && (op == OP_POWER);
  wire op_detect = cmd_evt && (op == OP_DETECT);
  wire op_prio = cmd_evt && (op == OP_PRIO);
  wire op_mask = cmd_evt && (op == OP_MASK);
  wire op_clear = cmd_evt && (op == OP_CLEAR);

  pss_port_t port_q;
  logic [2:0] boot_q;
  wire strap_take = (boot_q == BOOT_TAKE);
  wire prio_d = op_prio ? arg[0] : port_q.high_prio;
  wire shed_hit = shed_act && !prio_d;

  // forced off beats any host command
  // only a host power command brings it back, not autonomous reset
  wire power_d = hard_act ? 1'b0 :
                 shed_hit ? 1'b0 :
                 op_power ? arg[0] : port_q.power;
  wire det_d = shed_hit ? 1'b0 :
               op_detect ? arg[0] :
               (strap_take && auto_lvl) ? 1'b1 : port_q.det_en;
  wire cls_d = shed_hit ? 1'b0 :
               op_detect ? arg[1] :
               (strap_take && auto_lvl) ? 1'b1 : port_q.cls_en;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      port_q <= '0;
      boot_q <= 3'h0;
      sy_arm_q <= 1'b0;
      cmd_seen_q <= 1'b0;
      ara_seen_q <= 1'b0;
    end else begin
      port_q <= '{power: power_d, det_en: det_d, cls_en: cls_d,
                  high_prio: prio_d};
      boot_q <= (boot_q == 3'h7) ? boot_q : boot_q + 3'h1;
      sy_arm_q <= sy_arm_q || strap_take;
      cmd_seen_q <= sy_lvl_q[PIN_NUM];
      ara_seen_q <= sy_lvl_q[PIN_NUM+1];
    end
  end

  // ---------------------------------------------------------------
  // system domain: events and interrupt
  // ---------------------------------------------------------------
  logic [EVT_W-1:0] evt_q, mask_q;
  // a new event in the clearing cycle survives
  wire [EVT_W-1:0] evt_clr = ara_evt ? '1 : (op_clear ? arg[EVT_W-1:0] : '0);
  wire [EVT_W-1:0] evt_d = (evt_q & ~evt_clr) | PORT_EVENT_I;
  wire [EVT_W-1:0] mask_d = op_mask ? arg[EVT_W-1:0] : mask_q;
  wire int_d = |(evt_d & mask_d);
  wire [3:0] evt_pad = 4'(evt_q);

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      evt_q <= '0;
      mask_q <= EVT_W'(MASK_RESET);
      int_q <= 1'b0;
      stat_byte_q <= 8'h00;
    end else begin
      evt_q <= evt_d;
      mask_q <= mask_d;
      int_q <= int_d;
      stat_byte_q <= {port_q.power, port_q.det_en, port_q.cls_en,
                      port_q.high_prio, evt_pad};
    end
  end

  assign INT_N_O = 1'b0;
  assign INT_N_OE_O = int_q;
  assign PORT_CTRL_O = port_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_hard_off_port: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    hard_act |=> !port_q.power) else $error("port on while hard off held");

  a_stays_off: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    !port_q.power && !cmd_evt |=> !port_q.power) else $error("port on without command");

  a_prio_cmd: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    op_prio |=> port_q.high_prio == $past(arg[0])) else $error("priority not taken");

  a_shed_low_prio: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    shed_act && !port_q.high_prio |-> ##[1:SHED_BOUND] !port_q.power)
    else $error("low priority port not shed");

  a_shed_clears_en: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    shed_act && !prio_d |=> !port_q.det_en && !port_q.cls_en)
    else $error("shed left enables set");

  a_int_follows_evt: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    $rose(|(evt_q & mask_q)) |-> INT_N_OE_O) else $error("enabled event without interrupt");

  a_idle_no_drive: assert property (@(negedge SERIAL_CLK_I) disable iff (!RSTN_I)
    st_q == ST_IDLE |-> !oe_q) else $error("data driven while idle");

  a_primary_ack: assert property (@(negedge SERIAL_CLK_I) disable iff (!RSTN_I)
    st_q == ST_ADDR && cnt_q == 3'(BIT_CNT_LAST) && hit_primary && !start_seen
    && !stop_seen |=> st_q == ST_ACK_A && oe_q) else $error("primary address not acked");

  a_bcast_ack: assert property (@(negedge SERIAL_CLK_I) disable iff (!RSTN_I)
    st_q == ST_ADDR && cnt_q == 3'(BIT_CNT_LAST) && hit_bcast && !start_seen
    && !stop_seen |=> oe_q) else $error("broadcast not acked");

  a_ara_gated: assert property (@(negedge SERIAL_CLK_I) disable iff (!RSTN_I)
    st_q == ST_ADDR && cnt_q == 3'(BIT_CNT_LAST) && addr_rx == ADDR_ALERT_RESP
    && !int_l && !start_seen && !stop_seen |=> st_q == ST_IDLE)
    else $error("alert address answered without interrupt");

  a_arb_release: assert property (@(negedge SERIAL_CLK_I) disable iff (!RSTN_I)
    st_q == ST_TX && tx_q[7] && !sda_pos_q && !start_seen && !stop_seen
    |=> !oe_q && $stable(ara_tgl_q)) else $error("kept driving after lost arbitration");

  a_split_out: assert property (@(negedge SERIAL_CLK_I) disable iff (!RSTN_I)
    st_q == ST_ACK_W |-> oe_q ##1 !oe_q) else $error("write ack not one bit long");

endmodule

// *** include/pss_pkg.sv ***
// constants and carrier types of the port shutdown smbus slave
// assumes one system clock domain plus the serial bus clock domain
package pss_pkg;

  // ---------------------------------------------------------------
  // bus addresses
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_PRIMARY_HI = 3'h2;
  localparam logic [6:0] ADDR_BROADCAST = 7'h30;
  localparam logic [6:0] ADDR_ALERT_RESP = 7'h0c;
  localparam logic ALERT_ADDR_LSB = 1'h0;

  // ---------------------------------------------------------------
  // command byte: opcode in the high nibble, argument in the low one
  // ---------------------------------------------------------------
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam logic [3:0] OP_POWER = 4'h1;
  localparam logic [3:0] OP_DETECT = 4'h2;
  localparam logic [3:0] OP_PRIO = 4'h3;
  localparam logic [3:0] OP_MASK = 4'h4;
  localparam logic [3:0] OP_CLEAR = 4'h5;
  localparam int ARG_W = 4;
  localparam int BIT_CNT_LAST = 7;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [2:0] BOOT_TAKE = 3'h3;
  localparam int SYS_PERIOD_NS = 100;
  localparam int SHED_MAX_NS = 6500;
  localparam int SHED_MAX_CYC = SHED_MAX_NS / SYS_PERIOD_NS;

  // pin vector positions in the system domain synchroniser
  localparam int PIN_HARD = 0;
  localparam int PIN_SHED = 1;
  localparam int PIN_AUTO = 2;
  localparam int PIN_NUM = 3;

  // port control state carried to the core
  typedef struct packed {
    logic power;
    logic det_en;
    logic cls_en;
    logic high_prio;
  } pss_port_t;

  // serial engine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ACK_A = 7'b0000100,
    ST_RX = 7'b0001000,
    ST_ACK_W = 7'b0010000,
    ST_TX = 7'b0100000,
    ST_ACK_R = 7'b1000000
  } pss_link_st_t;

endpackage

// *** test/pss_host_model.sv ***
// host bus master model for the port shutdown slave bench
// assumes the bench builds the pulled-up data wire from both enables
`timescale 1ns/1ps
module pss_host_model (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // ---------------------------------------------------------------
  // bit timing, 32 ns serial clock, idle high between frames
  // ---------------------------------------------------------------
  // widens the low phase so the slave sees a stalling host
  logic slow = 1'b0;
  // pulls data low on read bits, like a rival with a lower address
  logic rival = 1'b0;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // data moves 4 ns after the fall to keep hold margin
  task automatic clk_bit(input logic b, output logic s);
    #4 sda_low_o = ~b;
    #(slow ? 44 : 12) scl_o = 1'b1;
    s = sda_i;
    #16 scl_o = 1'b0;
  endtask

  // odd offset keeps the serial edges off the system edges
  task automatic frame_start();
    #7 scl_o = 1'b0;
    #16 scl_o = 1'b1;
    #8 sda_low_o = 1'b1;
    #8 scl_o = 1'b0;
  endtask

  // stop needs one more falling edge before the slave sees it
  task automatic frame_stop();
    #4 sda_low_o = 1'b1;
    #12 scl_o = 1'b1;
    #8 sda_low_o = 1'b0;
    #8 scl_o = 1'b0;
    #16 scl_o = 1'b1;
  endtask

  // ---------------------------------------------------------------
  // byte level
  // ---------------------------------------------------------------
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  // released data line while reading unless rival is set, so arbitration is the slave's
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(!rival, s);
      d[i] = s;
    end
    clk_bit(~ack, s);
  endtask

  // host opens transfers
  // one byte each way, a read is ended by a nack
  task automatic xfer(input logic [6:0] addr, input logic rd, input logic [7:0] wd,
                      output logic ack, output logic [7:0] rdat);
    logic a2;
    rdat = 8'h00;
    frame_start();
    put_byte({addr, rd}, ack);
    if (ack && !rd) begin
      put_byte(wd, a2);
    end
    if (ack && rd) begin
      get_byte(1'b0, rdat);
    end
    frame_stop();
  endtask
endmodule

// *** test/port_shutdown_smbus_slave_tb_top.sv ***
// self-checking bench of the port shutdown slave
// assumes pss_pkg is compiled first and the host model beside it
`timescale 1ns/1ps
module port_shutdown_smbus_slave_tb_top;
  import pss_pkg::*;
  typedef struct packed {
    logic slow;
    logic [6:0] addr;
    logic [7:0] cmd;
    logic ack;
    logic [3:0] ctrl;
  } pss_row_t;
  localparam logic [6:0] prim_addr = {ADDR_PRIMARY_HI, 4'h5};
  localparam pss_row_t rows [6] = '{
    '{1'b0, prim_addr, 8'h21, 1'b1, 4'h4},
    '{1'b1, ADDR_BROADCAST, 8'h23, 1'b1, 4'h6},
    '{1'b0, ADDR_BROADCAST, 8'h31, 1'b1, 4'h7},
    '{1'b0, prim_addr, 8'h11, 1'b1, 4'hf},
    '{1'b0, prim_addr ^ 7'h01, 8'h10, 1'b0, 4'hf},
    '{1'b0, ADDR_ALERT_RESP, 8'h10, 1'b0, 4'hf}};
  logic sys_clk = 1'b0;
  logic rstn = 1'b1;
  logic hard_n = 1'b1;
  logic shed_n = 1'b1;
  logic auto_m = 1'b0;
  logic [3:0] ad = 4'h5;
  logic [3:0] evt = 4'h0;
  logic scl, host_low, sda, sda_out, sda_oe, int_n, int_oe, int_line, ack;
  logic [7:0] rd;
  pss_port_t ctrl;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  // ---------------------------------------------------------------
  // clock, wires and instances
  // ---------------------------------------------------------------
  always #50 sys_clk = ~sys_clk;

  assign sda = sda_oe ? (sda_out & ~host_low) : ~host_low;
  assign int_line = int_oe ? int_n : 1'b1;

  pss_slave #(.EVT_W(4)) i_dut (
    .SYS_CLK_I(sys_clk), .RSTN_I(rstn), .SERIAL_CLK_I(scl),
    .SERIAL_DATA_IN_PIN_I(sda), .SERIAL_DATA_OUT_PIN_O(sda_out),
    .SERIAL_DATA_OUT_PIN_OE_O(sda_oe), .ADDRESS_SELECT_PINS_I(ad),
    .HARD_PORT_OFF_PIN_N_I(hard_n), .PRIORITY_SHED_PIN_N_I(shed_n),
    .AUTO_MODE_I(auto_m), .PORT_EVENT_I(evt), .PORT_CTRL_O(ctrl),
    .INT_N_O(int_n), .INT_N_OE_O(int_oe));
  pss_host_model i_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));

  // ---------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t ns: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t ns: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hung handshake would otherwise stall the run forever
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one command per transfer, spaced well past eight system cycles
  task automatic cmd(input logic [6:0] a, input logic [7:0] c);
    i_host.xfer(a, 1'b0, c, ack, rd);
    repeat (12) @(posedge sys_clk);
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge sys_clk) evt <= v;
    @(posedge sys_clk) evt <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic do_reset();
    @(posedge sys_clk) rstn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk_byte({5'h00, ctrl.power, sda_oe, int_oe}, 8'h00, "outputs in reset");
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    chk_byte({4'h0, ctrl}, 8'h00, "control after reset");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      i_host.slow = rows[i].slow;
      cmd(rows[i].addr, rows[i].cmd);
      chk_bit(ack, rows[i].ack, "address ack");
      chk_byte({4'h0, ctrl}, {4'h0, rows[i].ctrl}, "port control");
    end
    i_host.slow = 1'b0;
    $display("test command table done");
    @(posedge sys_clk) hard_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk_byte({4'h0, ctrl}, 8'h07, "hard off");
    cmd(prim_addr, 8'h11);
    chk_bit(ctrl.power, 1'b0, "power while held off");
    @(posedge sys_clk) hard_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk_bit(ctrl.power, 1'b0, "power after pin release");
    cmd(prim_addr, 8'h11);
    chk_bit(ctrl.power, 1'b1, "power on by host");
    $display("test hard off done");
    @(posedge sys_clk) shed_n <= 1'b0;
    repeat (SHED_MAX_CYC) @(posedge sys_clk);
    chk_byte({4'h0, ctrl}, 8'h0f, "high priority kept");
    @(posedge sys_clk) shed_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    cmd(prim_addr, 8'h30);
    @(posedge sys_clk) shed_n <= 1'b0;
    repeat (SHED_MAX_CYC) @(posedge sys_clk);
    chk_byte({4'h0, ctrl}, 8'h00, "low priority shed");
    @(posedge sys_clk) shed_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk_byte({4'h0, ctrl}, 8'h00, "enables stay cleared");
    cmd(prim_addr, 8'h23);
    chk_byte({4'h0, ctrl}, 8'h06, "detect re-enabled");
    i_host.xfer(prim_addr, 1'b1, 8'h00, ack, rd);
    chk_byte(rd, 8'h60, "status read");
    $display("test shedding done");
    pulse(4'h1);
    chk_bit(int_oe, 1'b0, "masked event");
    cmd(prim_addr, 8'h5f);
    cmd(prim_addr, 8'h41);
    pulse(4'h2);
    chk_bit(int_oe, 1'b0, "other event masked");
    pulse(4'h1);
    chk_bit(int_oe, 1'b1, "enabled event");
    chk_bit(int_line, 1'b0, "interrupt line low");
    i_host.rival = 1'b1;
    i_host.xfer(ADDR_ALERT_RESP, 1'b1, 8'h00, ack, rd);
    i_host.rival = 1'b0;
    chk_byte(rd, 8'h00, "alert read lost to rival");
    repeat (10) @(posedge sys_clk);
    chk_bit(int_oe, 1'b1, "interrupt kept after lost arbitration");
    i_host.xfer(ADDR_ALERT_RESP, 1'b1, 8'h00, ack, rd);
    chk_bit(ack, 1'b1, "alert address ack");
    chk_byte(rd, {ADDR_PRIMARY_HI, 4'h5, ALERT_ADDR_LSB}, "alert reply");
    repeat (10) @(posedge sys_clk);
    chk_bit(int_oe, 1'b0, "interrupt released");
    chk_bit(int_line, 1'b1, "interrupt line high");
    i_host.xfer(ADDR_ALERT_RESP, 1'b1, 8'h00, ack, rd);
    chk_bit(ack, 1'b0, "alert without interrupt");
    $display("test interrupt done");
    // reset in autonomous mode re-enables detection and classification only
    cmd(prim_addr, 8'h11);
    @(posedge sys_clk) auto_m <= 1'b1;
    do_reset();
    chk_byte({4'h0, ctrl}, 8'h06, "autonomous reset");
    $display("test autonomous reset done");
    end_of_test();
  end
endmodule
